//--- verilog/bmm_pkg.sv
// constants and types for the banked memory map
package bmm_pkg;

	localparam int PC_W = 13;
	localparam int PROG_AW = 12;
	localparam int INSTR_W = 14;
	localparam int DAT_W = 8;
	localparam int FADDR_W = 9;
	localparam int RAM_DEPTH = 336;

	localparam logic [12:0] RESET_VECTOR = 13'h0000;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;

	// offsets inside every bank, then the flat address of the nv pointer
	localparam logic [6:0] OFS_INDIRECT = 7'h00;
	localparam logic [6:0] OFS_PCL = 7'h02;
	localparam logic [6:0] OFS_STATUS = 7'h03;
	localparam logic [6:0] OFS_POINTER = 7'h04;
	localparam logic [6:0] OFS_PROGRAM_COUNTER_UPPER_LATCH = 7'h0a;
	localparam logic [6:0] OFS_GPR_LO = 7'h20;
	localparam logic [6:0] OFS_COMMON_LO = 7'h70;
	localparam logic [8:0] NV_POINTER_ADDR = 9'h10d;

	// flat ram index layout
	localparam logic [8:0] RAM_COMMON_BASE = 9'h050;
	localparam logic [8:0] RAM_BANKED_BASE = 9'h060;
	localparam logic [8:0] BANK_GPR_SIZE = 9'h050;

	localparam int BANK_HI_BIT = 6;
	localparam int BANK_LO_BIT = 5;
	localparam int IND_BANK_BIT = 7;

	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] POINTER_RST = 8'h00;
	localparam logic [7:0] PROGRAM_COUNTER_UPPER_LATCH_RST = 8'h00;
	localparam logic [7:0] NV_POINTER_RST = 8'h00;
	localparam logic [7:0] RAM_RST = 8'h00;

	localparam int APB_IDX_LSB = 2;
	localparam int APB_IDX_MSB = 10;

	typedef enum logic [2:0] {
		BMM_K_NONE,
		BMM_K_INDIRECT,
		BMM_K_PCL,
		BMM_K_STATUS,
		BMM_K_POINTER,
		BMM_K_PROGRAM_COUNTER_UPPER_LATCH,
		BMM_K_NVPTR,
		BMM_K_RAM
	} bmm_kind_t;

	typedef struct packed {
		bmm_kind_t kind;
		logic [8:0] idx;
	} bmm_hit_t;

	typedef struct packed {
		logic [PC_W-1:0] pc;
		logic [7:0] status;
		logic [7:0] pointer;
		logic [7:0] program_counter_upper_latch;
		logic [7:0] nv_pointer;
		logic [RAM_DEPTH-1:0][7:0] ram;
		logic [INSTR_W-1:0] instr;
		logic [7:0] core_rdata;
		logic [31:0] prdata;
		logic ack;
	} bmm_state_t;

endpackage : bmm_pkg

//--- verilog/bmm_memory_map.sv
// banked data memory, program counter and apb window of the core
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module bmm_memory_map
	import bmm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [bmm_pkg::PROG_AW-1:0] prog_addr,
	input wire logic [bmm_pkg::INSTR_W-1:0] prog_rdata,
	output logic [bmm_pkg::INSTR_W-1:0] instr,
	output logic [bmm_pkg::PC_W-1:0] program_counter,
	input wire logic pc_step,
	input wire logic irq_take,
	input wire logic core_req,
	input wire logic core_we,
	input wire logic [6:0] core_addr,
	input wire logic [7:0] core_wdata,
	output logic [7:0] core_rdata,
	output logic [7:0] nv_pointer
);
	import bmm_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// address decoding

	function automatic bmm_hit_t map_addr(input logic [8:0] a);
		bmm_hit_t h;
		logic [6:0] o;
		logic [1:0] b;
		h.kind = BMM_K_NONE;
		h.idx = 9'h000;
		o = a[6:0];
		b = a[8:7];
		if (o == OFS_INDIRECT)
		begin
			h.kind = BMM_K_INDIRECT;
		end
		else if (o == OFS_PCL)
		begin
			h.kind = BMM_K_PCL;
		end
		else if (o == OFS_STATUS)
		begin
			h.kind = BMM_K_STATUS;
		end
		else if (o == OFS_POINTER)
		begin
			h.kind = BMM_K_POINTER;
		end
		else if (o == OFS_PROGRAM_COUNTER_UPPER_LATCH)
		begin
			h.kind = BMM_K_PROGRAM_COUNTER_UPPER_LATCH;
		end
		else if (a == NV_POINTER_ADDR)
		begin
			h.kind = BMM_K_NVPTR;
		end
		else if (o >= OFS_COMMON_LO)
		begin
			h.kind = BMM_K_RAM;
			h.idx = RAM_COMMON_BASE + {2'b00, o - OFS_COMMON_LO};
		end
		else if (o >= OFS_GPR_LO && b == 2'b00)
		begin
			h.kind = BMM_K_RAM;
			h.idx = {2'b00, o - OFS_GPR_LO};
		end
		else if (o >= OFS_GPR_LO)
		begin
			h.kind = BMM_K_RAM;
			h.idx = RAM_BANKED_BASE + ({7'h00, b} - 9'h001) * BANK_GPR_SIZE
				+ {2'b00, o - OFS_GPR_LO};
		end
		return h;
	endfunction : map_addr

	// the indirect register reached through the pointer leads nowhere, as on the core
	function automatic bmm_hit_t resolve(input bmm_state_t s, input logic [8:0] a);
		bmm_hit_t h;
		h = map_addr(a);
		if (h.kind == BMM_K_INDIRECT)
		begin
			h = map_addr({s.status[IND_BANK_BIT], s.pointer});
			if (h.kind == BMM_K_INDIRECT)
			begin
				h.kind = BMM_K_NONE;
			end
		end
		return h;
	endfunction : resolve

	function automatic logic [7:0] read_hit(input bmm_state_t s, input bmm_hit_t h);
		logic [7:0] v;
		v = 8'h00;
		case (h.kind)
			BMM_K_PCL: v = s.pc[7:0];
			BMM_K_STATUS: v = s.status;
			BMM_K_POINTER: v = s.pointer;
			BMM_K_PROGRAM_COUNTER_UPPER_LATCH: v = s.program_counter_upper_latch;
			BMM_K_NVPTR: v = s.nv_pointer;
			BMM_K_RAM: v = s.ram[h.idx];
			default: v = 8'h00;
		endcase
		return v;
	endfunction : read_hit

	function automatic bmm_state_t write_hit(input bmm_state_t s, input bmm_hit_t h,
		input logic [7:0] d);
		bmm_state_t r;
		r = s;
		case (h.kind)
			BMM_K_PCL: r.pc = {s.program_counter_upper_latch[4:0], d};
			BMM_K_STATUS: r.status = d;
			BMM_K_POINTER: r.pointer = d;
			BMM_K_PROGRAM_COUNTER_UPPER_LATCH: r.program_counter_upper_latch = d;
			BMM_K_NVPTR: r.nv_pointer = d;
			BMM_K_RAM: r.ram[h.idx] = d;
			default: r = s;
		endcase
		return r;
	endfunction : write_hit

	//////////////////////////////////////////////////////////////////////////
	// state

	bmm_state_t st;
	bmm_state_t next_st;
	bmm_hit_t core_hit;
	bmm_hit_t apb_hit;
	logic apb_mapped;
	logic [8:0] apb_faddr;

	always_comb
	begin
		next_st = st;
		// direct core accesses take the bank from status bits 6:5
		core_hit = resolve(st, {st.status[BANK_HI_BIT], st.status[BANK_LO_BIT],
			core_addr});
		apb_faddr = paddr[APB_IDX_MSB:APB_IDX_LSB];
		apb_mapped = (paddr[31:APB_IDX_MSB+1] == '0);
		apb_hit = resolve(st, apb_faddr);
		if (!apb_mapped)
		begin
			apb_hit.kind = BMM_K_NONE;
		end

		// fetch runs on its own bus, in parallel with any data access
		next_st.instr = prog_rdata;
		if (pc_step)
		begin
			next_st.pc = st.pc + 13'h0001;
		end

		// apb: one wait cycle while the core port is idle, then answer; the read is captured on the same edge that raises the ack
		next_st.ack = 1'b0;
		if (psel && penable && !st.ack && !core_req)
		begin
			next_st.ack = 1'b1;
			next_st.prdata = {24'h000000, read_hit(st, apb_hit)};
		end
		if (psel && penable && st.ack && pwrite)
		begin
			next_st = write_hit(next_st, apb_hit, pwdata[7:0]);
		end

		// core data port applied after the apb write, so it wins a same-cycle collision with it
		if (core_req)
		begin
			next_st.core_rdata = read_hit(st, core_hit);
			if (core_we)
			begin
				next_st = write_hit(next_st, core_hit, core_wdata);
			end
		end

		if (irq_take)
		begin
			next_st.pc = IRQ_VECTOR;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st.pc <= RESET_VECTOR;
			st.status <= STATUS_RST;
			st.pointer <= POINTER_RST;
			st.program_counter_upper_latch <= PROGRAM_COUNTER_UPPER_LATCH_RST;
			st.nv_pointer <= NV_POINTER_RST;
			st.ram <= {RAM_DEPTH{RAM_RST}};
			st.instr <= '0;
			st.core_rdata <= 8'h00;
			st.prdata <= 32'h00000000;
			st.ack <= 1'b0;
		end
		else
		begin
			st <= next_st;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs

	// upper counter bit is dropped, so fetches alias every 4K words
	assign prog_addr = st.pc[PROG_AW-1:0];
	assign program_counter = st.pc;
	assign instr = st.instr;
	assign core_rdata = st.core_rdata;
	assign nv_pointer = st.nv_pointer;
	assign prdata = st.prdata;
	assign pready = st.ack;
	assign pslverr = 1'b0;

endmodule : bmm_memory_map

//--- dv/bmm_prog_store.sv
// program store model answering fetches from the memory map
`timescale 1ns/1ps
module bmm_prog_store
	import bmm_pkg::*;
(
	input wire logic [bmm_pkg::PROG_AW-1:0] prog_addr,
	output logic [bmm_pkg::INSTR_W-1:0] prog_rdata
);
	// word follows its address so a wrong alias shows up at once
	assign prog_rdata = {2'b10, prog_addr};
endmodule : bmm_prog_store

//--- dv/bmm_memory_map_sva.sv
// port assertions for the memory map
`timescale 1ns/1ps
module bmm_sva
	import bmm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [13:0] prog_rdata,
	input wire logic [13:0] instr,
	input wire logic [12:0] program_counter,
	input wire logic pc_step,
	input wire logic irq_take,
	input wire logic core_req,
	input wire logic core_we,
	input wire logic [6:0] core_addr,
	input wire logic [7:0] core_rdata
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_no_slverr: assert property (!pslverr) else $error("slave error");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
	a_ready_after: assert property (
		psel && penable && !pready && !core_req |=> pready) else $error("no ready");
	a_rdata_upper: assert property (
		pready |-> prdata[31:8] == 24'h0) else $error("upper data");
	// the edge that leaves reset still loads the reset word, so skip it
	a_instr_capture: assert property (
		$past(presetn) |-> instr == $past(prog_rdata)) else $error("instr lost");
	a_irq_vector: assert property (
		irq_take |=> program_counter == 13'h0004) else $error("irq vector");
	a_step_inc: assert property (pc_step && !irq_take && !core_req && !pready
		|=> program_counter == $past(program_counter) + 13'h1) else $error("step");
	a_unimpl_zero: assert property (core_req && !core_we && core_addr == 7'h01
		|=> core_rdata == 8'h00) else $error("unimplemented read");
endmodule : bmm_sva
bind bmm_memory_map bmm_sva u_sva (.*);

//--- dv/tb_banked_memory_map.sv
// self-checking bench for the banked memory map
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
	$display("Error %s exp %h got %h", n, e, s); end end
module tb_banked_memory_map;
	import bmm_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic pc_step = 0, irq_take = 0, core_req = 0, core_we = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
	logic [6:0] core_addr = 0;
	logic [7:0] core_wdata = 0, core_rdata, nv_pointer;
	logic [11:0] prog_addr;
	logic [13:0] prog_rdata, instr;
	logic [12:0] program_counter;
	int mismatches = 0, n_compared = 0;
	// write address, data, read address, expected byte
	logic [33:0] rows [6] = '{{9'h020, 8'ha5, 9'h020, 8'ha5}, {9'h0a0, 8'h5a, 9'h0a0, 8'h5a},
		{9'h1f5, 8'h3c, 9'h075, 8'h3c}, {9'h001, 8'h77, 9'h001, 8'h00},
		{9'h10d, 8'hff, 9'h10d, 8'hff}, {9'h18a, 8'h1f, 9'h00a, 8'h1f}};
	bmm_memory_map dut (.*);
	bmm_prog_store u_prog (.*);
	initial
	forever #20 pclk = ~pclk;
	//////////
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim
	// bounded wait: a missing ready ends the run
	task automatic apb(input logic w, input logic [8:0] a, input logic [7:0] d);
		int i;
		i = 0;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, 21'h0, a, 2'b00, 24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1)
		begin
			mismatches++;
			end_sim;
		end
		rd = prdata;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic core(input logic w, input logic [6:0] a, input logic [7:0] d);
		@(posedge pclk);
		{core_req, core_we, core_addr, core_wdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		{core_req, core_we} <= 2'b00;
		#1;
	endtask : core
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		#1 `CHK("pc reset", 13'h0000, program_counter)
		foreach (rows[k])
		begin
			apb(1, rows[k][33:25], rows[k][24:17]);
			apb(0, rows[k][16:8], 8'h00);
			`CHK("apb read", {24'h0, rows[k][7:0]}, rd)
			$display("row %0d done", k);
		end
		`CHK("nv pointer", 8'hff, nv_pointer)
		apb(1, 9'h003, 8'h20);
		apb(1, 9'h004, 8'h20);
		core(0, 7'h20, 8'h00);
		`CHK("bank one ram", 8'h5a, core_rdata)
		core(0, 7'h03, 8'h00);
		`CHK("status mirror", 8'h20, core_rdata)
		core(0, 7'h00, 8'h00);
		`CHK("indirect read", 8'ha5, core_rdata)
		core(1, 7'h00, 8'h66);
		`CHK("read before write", 8'ha5, core_rdata)
		apb(0, 9'h020, 8'h00);
		`CHK("indirect write", 32'h00000066, rd)
		core(1, 7'h70, 8'h99);
		apb(0, 9'h170, 8'h00);
		`CHK("common ram", 32'h00000099, rd)
		core(1, 7'h01, 8'h44);
		core(0, 7'h01, 8'h00);
		`CHK("unimplemented", 8'h00, core_rdata)
		$display("core port test done");
		apb(1, 9'h002, 8'h20);
		repeat (3) @(posedge pclk);
		#1 `CHK("pcl load", 13'h1f20, program_counter)
		`CHK("fetch wrap", 12'hf20, prog_addr)
		`CHK("instr", {2'b10, 12'hf20}, instr)
		@(posedge pclk);
		{irq_take, pc_step} <= 2'b11;
		@(posedge pclk);
		irq_take <= 0;
		#1 `CHK("irq vector", 13'h0004, program_counter)
		@(posedge pclk);
		pc_step <= 0;
		#1 `CHK("step", 13'h0005, program_counter)
		// quiet edges so the step check ends before reset disables it
		repeat (2) @(posedge pclk);
		presetn <= 0;
		#1 `CHK("pc second reset", 13'h0000, program_counter)
		@(posedge pclk);
		presetn <= 1;
		#1 `CHK("no ready after reset", 1'b0, pready)
		apb(0, 9'h003, 8'h00);
		`CHK("status reset", 32'h00000000, rd)
		apb(0, 9'h020, 8'h00);
		`CHK("ram reset", 32'h00000000, rd)
		`CHK("pc held", 13'h0000, program_counter)
		$display("pc and reset test done");
		end_sim;
	end
endmodule : tb_banked_memory_map
